// >>> drt_pkg.sv
// Shared constants and types for the read turnaround timing link
package drt_pkg;
    localparam int CLK_PERIOD_PS = 100000;
    localparam int T_RTP_MIN_PS = 7500;
    localparam int NCK_RTP_MIN = 4;
    localparam int T_RTP_NS_CYC = (T_RTP_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int T_RTP_CYC = (T_RTP_NS_CYC > NCK_RTP_MIN) ? T_RTP_NS_CYC : NCK_RTP_MIN;
    localparam int PAR_LAT = 0;
    localparam int CWL_LOWEST = 9;
    localparam int POSTAMBLE_CYC = 1;
    localparam int BEATS_BL8 = 8;
    localparam int BEATS_BC4 = 4;
    localparam logic [1:0] BL_FIX8 = 2'h0;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam logic [1:0] BL_FIX4 = 2'h2;
    localparam int ADDR_W = 18;
    localparam int A12_BIT = 12;
    localparam int LAT_W = 5;
    localparam int MR_BL_POS = 0;
    localparam int MR_CL_POS = 2;
    localparam int MR_AL_POS = 7;
    localparam int MR_CWL_POS = 12;
    localparam int MR_WPRE_POS = 17;
    localparam int CNT_W = 8;
    localparam logic [7:0] REG_CFG = 8'h00;
    localparam logic [7:0] REG_REQ = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_RDATA = 8'h10;
    localparam int REQ_OP_POS = 0;
    localparam int REQ_BANK_POS = 4;
    localparam int REQ_A12_POS = 8;
    localparam int REQ_COL_POS = 16;
    localparam int ST_PEND_BIT = 0;
    localparam int ST_RNEW_BIT = 1;
    localparam int ST_WDRV_BIT = 2;
    localparam int ST_RCAP_BIT = 3;
    localparam logic [31:0] CFG_RESET = 32'h0000_902C;
    localparam logic [31:0] WDATA_RESET = 32'h0000_0000;
    typedef enum logic [2:0] {CMD_DES, CMD_MRS, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE} drt_cmd_type;
endpackage

// >>> drt_link_if.sv
// Command and shared data bus between controller and memory
`timescale 1ns/1ps
interface drt_link_if
    import drt_pkg::*;
#(
    parameter int BANK_W = 2,
    parameter int DQ_W = 8
);
    drt_cmd_type cmd;
    logic [ADDR_W-1:0] addr;
    logic [BANK_W-1:0] bank;
    logic [DQ_W-1:0] ctl_dq;
    logic ctl_dq_oe_n;
    logic [DQ_W-1:0] dev_dq;
    logic dev_dq_oe_n;
    logic [DQ_W-1:0] dq;
    logic clash;
    // Resolved wire level; both drivers on at once is a clash
    assign dq = !dev_dq_oe_n ? dev_dq : (!ctl_dq_oe_n ? ctl_dq : '0);
    assign clash = !dev_dq_oe_n && !ctl_dq_oe_n;
    modport ctl (output cmd, addr, bank, ctl_dq, ctl_dq_oe_n, input dq);
    modport dev (input cmd, addr, bank, dq, output dev_dq, dev_dq_oe_n);
endinterface

// >>> drt_dram.sv
// Memory end: burst length selection, read latency and write capture
`timescale 1ns/1ps
module drt_dram
    import drt_pkg::*;
#(
    parameter int BANKS = 4,
    parameter int COL_W = 4,
    parameter int DQ_W = 8,
    parameter int LAT_MAX = 64
)
(
    // Clock and reset
    input wire logic CLOCK,
    input wire logic ARST_N,
    // Link
    drt_link_if.dev LINK,
    // Status
    output logic BURST_LONG,
    output logic RD_BUSY,
    output logic WR_BUSY
);
    localparam int BANK_W = (BANKS > 1) ? $clog2(BANKS) : 1;
    localparam int MA_W = BANK_W + COL_W;

    typedef struct packed {logic v; logic len8; logic [MA_W-1:0] adr;} drt_slot_type;

    if (LAT_MAX < 2 ** (LAT_W + 1) || COL_W > A12_BIT || DQ_W > 32)
    begin : g_bad
        $error("drt_dram: unsupported parameters");
    end

    logic [1:0] bl;
    logic [LAT_W-1:0] cl;
    logic [LAT_W-1:0] al;
    logic [LAT_W-1:0] cwl;
    logic [LAT_W+1:0] rl;
    logic [LAT_W+1:0] wl;
    logic is_rd;
    logic is_wr;
    logic len8;
    logic [MA_W-1:0] cmd_adr;
    drt_slot_type rd_line [LAT_MAX:0];
    drt_slot_type wr_line [LAT_MAX:0];
    logic [DQ_W-1:0] mem [2**MA_W];
    logic [3:0] rd_left;
    logic [MA_W-1:0] rd_adr;
    logic wr_on;
    logic [3:0] wr_left;
    logic [MA_W-1:0] wr_adr;

    function automatic logic burst8(input logic [1:0] f, input logic a12);
        if (f == BL_FIX4)
            return 1'b0;
        else if (f == BL_OTF)
            return a12;
        return 1'b1;
    endfunction

    assign is_rd = (LINK.cmd == CMD_RD);
    assign is_wr = (LINK.cmd == CMD_WR);
    assign len8 = burst8(bl, LINK.addr[A12_BIT]);
    assign cmd_adr = {LINK.bank, LINK.addr[COL_W-1:0]};
    assign rl = (LAT_W+2)'(cl) + (LAT_W+2)'(al) + (LAT_W+2)'(PAR_LAT);
    assign wl = (LAT_W+2)'(cwl) + (LAT_W+2)'(al);
    assign rd_line[LAT_MAX] = '0;
    assign wr_line[LAT_MAX] = '0;
    assign RD_BUSY = ~LINK.dev_dq_oe_n;
    assign WR_BUSY = wr_on;

    // Mode setting
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            bl <= CFG_RESET[MR_BL_POS +: 2];
            cl <= CFG_RESET[MR_CL_POS +: LAT_W];
            al <= CFG_RESET[MR_AL_POS +: LAT_W];
            cwl <= CFG_RESET[MR_CWL_POS +: LAT_W];
        end
        else if (LINK.cmd == CMD_MRS)
        begin
            bl <= LINK.addr[MR_BL_POS +: 2];
            cl <= LINK.addr[MR_CL_POS +: LAT_W];
            al <= LINK.addr[MR_AL_POS +: LAT_W];
            cwl <= LINK.addr[MR_CWL_POS +: LAT_W];
        end
    end

    // Command is seen one edge late, hence the offset of two
    for (genvar i = 0; i < LAT_MAX; i++)
    begin : g_slot
        always_ff @(posedge CLOCK or negedge ARST_N)
        begin
            if (!ARST_N)
            begin
                rd_line[i] <= '0;
                wr_line[i] <= '0;
            end
            else
            begin
                if (is_rd && int'(rl) == i + 2)
                    rd_line[i] <= '{1'b1, len8, cmd_adr};
                else
                    rd_line[i] <= rd_line[i+1];
                if (is_wr && int'(wl) == i + 2)
                    wr_line[i] <= '{1'b1, len8, cmd_adr};
                else
                    wr_line[i] <= wr_line[i+1];
            end
        end
    end

    // Bus is freed right after the last beat
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            LINK.dev_dq <= '0;
            LINK.dev_dq_oe_n <= 1'b1;
            rd_left <= 4'h0;
            rd_adr <= '0;
        end
        else if (rd_line[0].v)
        begin
            LINK.dev_dq <= mem[rd_line[0].adr];
            LINK.dev_dq_oe_n <= 1'b0;
            rd_left <= rd_line[0].len8 ? 4'(BEATS_BL8 - 1) : 4'(BEATS_BC4 - 1);
            rd_adr <= rd_line[0].adr + MA_W'(1);
        end
        else if (rd_left != 4'h0)
        begin
            LINK.dev_dq <= mem[rd_adr];
            rd_left <= rd_left - 4'h1;
            rd_adr <= rd_adr + MA_W'(1);
        end
        else
        begin
            LINK.dev_dq <= '0;
            LINK.dev_dq_oe_n <= 1'b1;
        end
    end

    // Write capture window
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            wr_on <= 1'b0;
            wr_left <= 4'h0;
            wr_adr <= '0;
        end
        else if (wr_line[0].v)
        begin
            wr_on <= 1'b1;
            wr_left <= wr_line[0].len8 ? 4'(BEATS_BL8 - 1) : 4'(BEATS_BC4 - 1);
            wr_adr <= wr_line[0].adr;
        end
        else if (wr_on && wr_left != 4'h0)
        begin
            wr_left <= wr_left - 4'h1;
            wr_adr <= wr_adr + MA_W'(1);
        end
        else
            wr_on <= 1'b0;
    end

    // Storage has no reset; reads of unwritten cells return unknown data
    always_ff @(posedge CLOCK)
    begin
        if (wr_on)
            mem[wr_adr] <= LINK.dq;
    end

    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
            BURST_LONG <= 1'b0;
        else if (is_rd || is_wr)
            BURST_LONG <= len8;
    end
endmodule

// >>> drt_ctrl.sv
// Controller end: APB registers, command spacing and data bus scheduling
`timescale 1ns/1ps
module drt_ctrl
    import drt_pkg::*;
#(
    parameter int BANKS = 4,
    parameter int COL_W = 4,
    parameter int DQ_W = 8,
    parameter int LAT_MAX = 64,
    parameter int T_RAS_CYC = 28,
    parameter int T_RP_CYC = 11,
    parameter int T_RC_CYC = 39
)
(
    // Clock and reset
    input wire logic CLOCK,
    input wire logic ARST_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Link
    drt_link_if.ctl LINK
);
    localparam int BANK_W = (BANKS > 1) ? $clog2(BANKS) : 1;
    localparam int CNT_MAX = 2 ** CNT_W - 1;

    typedef enum {ST_IDLE, ST_WAIT} drt_state_type;
    typedef struct packed {logic v; logic len8;} drt_ev_type;

    if (LAT_MAX < 2 ** (LAT_W + 1) || COL_W > A12_BIT || DQ_W > 32 || T_RC_CYC > CNT_MAX
        || T_RAS_CYC > CNT_MAX || T_RP_CYC > CNT_MAX || T_RAS_CYC < 1 || T_RP_CYC < 1)
    begin : g_bad
        $error("drt_ctrl: unsupported parameters");
    end

    drt_state_type state;
    drt_state_type next_state;
    logic [31:0] cfg;
    logic [31:0] req;
    logic [31:0] wbase;
    logic [31:0] rdata;
    logic rnew;
    logic pend_mrs;
    logic [31:0] rd_value;
    logic bad;
    logic apply;
    logic issue;
    logic legal;
    drt_cmd_type op_now;
    logic [BANK_W-1:0] req_bank;
    logic req_len8;
    logic [LAT_W-1:0] cwl_eff;
    logic [ADDR_W-1:0] next_addr;
    logic [1:0] p_bl;
    logic [LAT_W-1:0] p_cl;
    logic [LAT_W-1:0] p_al;
    logic [LAT_W-1:0] p_cwl;
    logic p_wpre;
    logic [LAT_W+1:0] p_rl;
    logic [LAT_W+1:0] p_wl;
    logic [CNT_W-1:0] since_act [BANKS];
    logic [CNT_W-1:0] since_pre [BANKS];
    logic [CNT_W-1:0] since_rd [BANKS];
    logic pre_ok [BANKS];
    logic act_ok [BANKS];
    logic [CNT_W-1:0] since_rd_any;
    logic last_len8;
    logic wr_ok;
    logic quiet;
    drt_ev_type rcap [LAT_MAX:0];
    drt_ev_type wdrv [LAT_MAX:0];
    logic cap_on;
    logic [3:0] cap_left;
    logic [3:0] drv_left;

    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] c);
        return (c == CNT_W'(CNT_MAX)) ? c : c + CNT_W'(1);
    endfunction

    assign PREADY = 1'b1;
    assign apply = PSEL && PENABLE && PWRITE && !PSLVERR;
    assign req_bank = req[REQ_BANK_POS +: BANK_W];
    assign op_now = pend_mrs ? CMD_MRS : drt_cmd_type'(req[REQ_OP_POS +: 3]);
    assign req_len8 = (p_bl == BL_FIX4) ? 1'b0 : (p_bl == BL_OTF) ? req[REQ_A12_POS] : 1'b1;
    assign p_rl = (LAT_W+2)'(p_cl) + (LAT_W+2)'(p_al) + (LAT_W+2)'(PAR_LAT);
    assign p_wl = (LAT_W+2)'(p_cwl) + (LAT_W+2)'(p_al);
    assign issue = (state == ST_WAIT) && legal;
    assign rcap[LAT_MAX] = '0;
    assign wdrv[LAT_MAX] = '0;

    // Two-clock preamble needs CWL one above its lowest
    assign cwl_eff = (cfg[MR_WPRE_POS] && cfg[MR_CWL_POS +: LAT_W] < LAT_W'(CWL_LOWEST + 1))
        ? LAT_W'(CWL_LOWEST + 1) : cfg[MR_CWL_POS +: LAT_W];

    // Register decode, judged in the setup cycle
    always_comb
    begin
        rd_value = 32'h0000_0000;
        bad = 1'b0;
        if (PADDR == REG_CFG)
        begin
            rd_value = cfg;
            bad = PWRITE && (state != ST_IDLE);
        end
        else if (PADDR == REG_REQ)
        begin
            rd_value = req;
            bad = PWRITE && (state != ST_IDLE);
        end
        else if (PADDR == REG_WDATA)
            rd_value = wbase;
        else if (PADDR == REG_STATUS)
        begin
            rd_value[ST_PEND_BIT] = (state != ST_IDLE);
            rd_value[ST_RNEW_BIT] = rnew;
            rd_value[ST_WDRV_BIT] = ~LINK.ctl_dq_oe_n;
            rd_value[ST_RCAP_BIT] = cap_on;
            bad = PWRITE;
        end
        else if (PADDR == REG_RDATA)
        begin
            rd_value = rdata;
            bad = PWRITE;
        end
        else
            bad = 1'b1;
    end

    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end
        else if (PSEL && !PENABLE)
        begin
            PRDATA <= PWRITE ? 32'h0000_0000 : rd_value;
            PSLVERR <= bad;
        end
    end

    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            cfg <= CFG_RESET;
            req <= 32'h0000_0000;
            wbase <= WDATA_RESET;
            pend_mrs <= 1'b0;
        end
        else if (apply)
        begin
            if (PADDR == REG_CFG)
                cfg <= PWDATA;
            if (PADDR == REG_REQ)
                req <= PWDATA;
            if (PADDR == REG_WDATA)
                wbase <= PWDATA;
            if (PADDR == REG_CFG || PADDR == REG_REQ)
                pend_mrs <= (PADDR == REG_CFG);
        end
    end

    // Mode changes wait for a quiet bus so latencies never shift mid-burst
    always_comb
    begin
        quiet = !cap_on && LINK.ctl_dq_oe_n;
        for (int i = 0; i < LAT_MAX; i++)
            quiet = quiet && !rcap[i].v && !wdrv[i].v;
        case (op_now)
            CMD_ACT: legal = act_ok[req_bank];
            CMD_PRE: legal = pre_ok[req_bank];
            CMD_WR: legal = wr_ok;
            CMD_MRS: legal = quiet;
            default: legal = 1'b1;
        endcase
    end

    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (apply && (PADDR == REG_CFG || PADDR == REG_REQ))
                    next_state = ST_WAIT;
            ST_WAIT:
                if (legal)
                    next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    always_comb
    begin
        next_addr = '0;
        if (pend_mrs)
            next_addr = {cfg[MR_WPRE_POS], cwl_eff, cfg[MR_CWL_POS-1:0]};
        else
        begin
            next_addr[A12_BIT] = req[REQ_A12_POS];
            next_addr[COL_W-1:0] = req[REQ_COL_POS +: COL_W];
        end
    end

    // One command per issue, deselect otherwise
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            LINK.cmd <= CMD_DES;
            LINK.addr <= '0;
            LINK.bank <= '0;
        end
        else if (issue)
        begin
            LINK.cmd <= op_now;
            LINK.addr <= next_addr;
            LINK.bank <= req_bank;
        end
        else
            LINK.cmd <= CMD_DES;
    end

    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            p_bl <= CFG_RESET[MR_BL_POS +: 2];
            p_cl <= CFG_RESET[MR_CL_POS +: LAT_W];
            p_al <= CFG_RESET[MR_AL_POS +: LAT_W];
            p_cwl <= CFG_RESET[MR_CWL_POS +: LAT_W];
            p_wpre <= CFG_RESET[MR_WPRE_POS];
        end
        else if (issue && op_now == CMD_MRS)
        begin
            p_bl <= cfg[MR_BL_POS +: 2];
            p_cl <= cfg[MR_CL_POS +: LAT_W];
            p_al <= cfg[MR_AL_POS +: LAT_W];
            p_cwl <= cwl_eff;
            p_wpre <= cfg[MR_WPRE_POS];
        end
    end

    // A count of k allows spacing k+1 at the next issue
    for (genvar b = 0; b < BANKS; b++)
    begin : g_bank
        logic hit;
        assign hit = issue && req_bank == BANK_W'(b);
        assign pre_ok[b] = (int'(since_rd[b]) >= int'(p_al) + T_RTP_CYC - 1)
            && (int'(since_act[b]) >= T_RAS_CYC - 1);
        assign act_ok[b] = (int'(since_pre[b]) >= T_RP_CYC - 1)
            && (int'(since_act[b]) >= T_RC_CYC - 1);
        always_ff @(posedge CLOCK or negedge ARST_N)
        begin
            if (!ARST_N)
            begin
                since_act[b] <= CNT_W'(CNT_MAX);
                since_pre[b] <= CNT_W'(CNT_MAX);
                since_rd[b] <= CNT_W'(CNT_MAX);
            end
            else
            begin
                since_act[b] <= (hit && op_now == CMD_ACT) ? '0 : sat_inc(since_act[b]);
                since_pre[b] <= (hit && op_now == CMD_PRE) ? '0 : sat_inc(since_pre[b]);
                since_rd[b] <= (hit && op_now == CMD_RD) ? '0 : sat_inc(since_rd[b]);
            end
        end
    end

    // Preamble may start only after read burst and postamble
    assign wr_ok = ({1'b0, since_rd_any} + 9'(p_wl) + 9'(1)) >= (9'(p_rl)
        + (last_len8 ? 9'(BEATS_BL8) : 9'(BEATS_BC4)) + 9'(POSTAMBLE_CYC)
        + (p_wpre ? 9'(2) : 9'(1)));

    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            since_rd_any <= CNT_W'(CNT_MAX);
            last_len8 <= 1'b0;
        end
        else if (issue && op_now == CMD_RD)
        begin
            since_rd_any <= '0;
            last_len8 <= req_len8;
        end
        else
            since_rd_any <= sat_inc(since_rd_any);
    end

    for (genvar i = 0; i < LAT_MAX; i++)
    begin : g_slot
        always_ff @(posedge CLOCK or negedge ARST_N)
        begin
            if (!ARST_N)
            begin
                rcap[i] <= '0;
                wdrv[i] <= '0;
            end
            else
            begin
                if (issue && op_now == CMD_RD && int'(p_rl) == i + 1)
                    rcap[i] <= '{1'b1, req_len8};
                else
                    rcap[i] <= rcap[i+1];
                if (issue && op_now == CMD_WR && int'(p_wl) == i + 1)
                    wdrv[i] <= '{1'b1, req_len8};
                else
                    wdrv[i] <= wdrv[i+1];
            end
        end
    end

    // Read capture keeps the last four beats
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            cap_on <= 1'b0;
            cap_left <= 4'h0;
        end
        else if (rcap[0].v)
        begin
            cap_on <= 1'b1;
            cap_left <= rcap[0].len8 ? 4'(BEATS_BL8 - 1) : 4'(BEATS_BC4 - 1);
        end
        else if (cap_on && cap_left != 4'h0)
            cap_left <= cap_left - 4'h1;
        else
            cap_on <= 1'b0;
    end

    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            rdata <= 32'h0000_0000;
            rnew <= 1'b0;
        end
        else
        begin
            if (cap_on)
                rdata <= 32'({rdata, LINK.dq});
            // A burst end beats a clearing read
            if (cap_on && cap_left == 4'h0)
                rnew <= 1'b1;
            else if (PSEL && PENABLE && !PWRITE && PADDR == REG_RDATA)
                rnew <= 1'b0;
        end
    end

    // Write data counts up from the programmed base
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            LINK.ctl_dq <= '0;
            LINK.ctl_dq_oe_n <= 1'b1;
            drv_left <= 4'h0;
        end
        else if (wdrv[0].v)
        begin
            LINK.ctl_dq <= wbase[DQ_W-1:0];
            LINK.ctl_dq_oe_n <= 1'b0;
            drv_left <= wdrv[0].len8 ? 4'(BEATS_BL8 - 1) : 4'(BEATS_BC4 - 1);
        end
        else if (!LINK.ctl_dq_oe_n && drv_left != 4'h0)
        begin
            LINK.ctl_dq <= LINK.ctl_dq + DQ_W'(1);
            drv_left <= drv_left - 4'h1;
        end
        else
        begin
            LINK.ctl_dq <= '0;
            LINK.ctl_dq_oe_n <= 1'b1;
        end
    end
endmodule

// >>> drt_link_props.sv
// Concurrent checks on the link between controller and memory
`timescale 1ns/1ps
module drt_link_props
    import drt_pkg::*;
#(
    parameter int BANK_W = 2,
    parameter int T_RAS_CYC = 28,
    parameter int T_RP_CYC = 11,
    parameter int T_RC_CYC = 39
)
(
    // Clock and reset
    input wire logic CLOCK,
    input wire logic ARST_N,
    // Link
    input drt_cmd_type cmd,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [BANK_W-1:0] bank,
    input wire logic ctl_dq_oe_n,
    input wire logic dev_dq_oe_n,
    input wire logic clash
);
    logic [1:0] bl;
    logic [LAT_W-1:0] cl, al, cwl;
    logic wpre;
    logic [CNT_W-1:0] rd_cnt, wr_cnt, act_cnt, pre_cnt;
    logic [3:0] rd_n, wr_n;
    int cwl_eff;
    function automatic logic [CNT_W-1:0] sat(logic [CNT_W-1:0] c);
        return (c == '1) ? c : c + 1'b1;
    endfunction
    function automatic logic [3:0] beats(logic [1:0] f, logic a12);
        return (f == BL_FIX4 || (f == BL_OTF && !a12)) ? 4'h4 : 4'h8;
    endfunction
    assign cwl_eff = (wpre && cwl < CWL_LOWEST + 1) ? CWL_LOWEST + 1 : int'(cwl);
    // Mirror of the mode word, so expectations follow reprogramming
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
            {wpre, cwl, al, cl, bl} <= CFG_RESET[17:0];
        else if (cmd == CMD_MRS)
            {wpre, cwl, al, cl, bl} <= addr;
    end
    // Counters per command kind; a limitation: not per bank
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            rd_cnt <= '1;
            wr_cnt <= '1;
            act_cnt <= '1;
            pre_cnt <= '1;
            rd_n <= 4'h8;
            wr_n <= 4'h8;
        end
        else
        begin
            rd_cnt <= (cmd == CMD_RD) ? 8'h01 : sat(rd_cnt);
            wr_cnt <= (cmd == CMD_WR) ? 8'h01 : sat(wr_cnt);
            act_cnt <= (cmd == CMD_ACT) ? 8'h01 : sat(act_cnt);
            pre_cnt <= (cmd == CMD_PRE) ? 8'h01 : sat(pre_cnt);
            if (cmd == CMD_RD)
                rd_n <= beats(bl, addr[A12_BIT]);
            if (cmd == CMD_WR)
                wr_n <= beats(bl, addr[A12_BIT]);
        end
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);
    a_no_bus_clash: assert property (!clash)
        else $error("both ends drive the data bus");
    a_read_latency: assert property ($fell(dev_dq_oe_n) |-> rd_cnt == cl + al + PAR_LAT)
        else $error("read data at wrong latency");
    a_read_long: assert property ($fell(dev_dq_oe_n) && rd_n == 4'h8 |->
        !dev_dq_oe_n [*8] ##1 dev_dq_oe_n)
        else $error("long read burst not eight beats");
    a_read_chop: assert property ($fell(dev_dq_oe_n) && rd_n == 4'h4 |->
        !dev_dq_oe_n [*4] ##1 dev_dq_oe_n)
        else $error("chopped read burst not four beats");
    a_write_length: assert property ($fell(ctl_dq_oe_n) |->
        !ctl_dq_oe_n [*4] ##1 (ctl_dq_oe_n == (wr_n == 4'h4)))
        else $error("write burst length wrong");
    a_write_latency: assert property ($fell(ctl_dq_oe_n) |-> wr_cnt == cwl_eff + al)
        else $error("write data at wrong latency");
    a_pre_after_read: assert property (cmd == CMD_PRE |-> rd_cnt >= al + 4)
        else $error("precharge too soon after read");
    a_pre_after_act: assert property (cmd == CMD_PRE |-> act_cnt >= T_RAS_CYC)
        else $error("precharge too soon after activate");
    a_act_spacing: assert property (cmd == CMD_ACT |->
        pre_cnt >= T_RP_CYC && act_cnt >= T_RC_CYC)
        else $error("activate too soon");
    cover property (cmd == CMD_PRE);
    cover property ($fell(dev_dq_oe_n) && rd_n == 4'h4);
    cover property ($fell(ctl_dq_oe_n) && wpre);
endmodule

// >>> ddr4_read_turnaround_timing_tb_top.sv
// Testbench joining controller and memory over the link
`timescale 1ns/1ps
module ddr4_read_turnaround_timing_tb_top
    import drt_pkg::*;
;
    logic CLOCK = 0, ARST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [7:0] PADDR = '0;
    logic [31:0] PWDATA = '0, PRDATA, rd;
    logic PREADY, PSLVERR, er, BURST_LONG, RD_BUSY, WR_BUSY;
    logic seen_clash = 0, dprev = 1, cprev = 1;
    int errors = 0, checks = 0, cyc = 0, t_act, t_act0, t_rd, t_wr, t_pre, t_beat, t_wf, nb;
    drt_link_if i_drt_link_if ();
    drt_ctrl i_drt_ctrl (.CLOCK, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
        .PREADY, .PSLVERR, .LINK(i_drt_link_if));
    drt_dram i_drt_dram (.CLOCK, .ARST_N, .LINK(i_drt_link_if), .BURST_LONG, .RD_BUSY,
        .WR_BUSY);
    drt_link_props i_props (.CLOCK, .ARST_N, .cmd(i_drt_link_if.cmd),
        .addr(i_drt_link_if.addr), .bank(i_drt_link_if.bank),
        .ctl_dq_oe_n(i_drt_link_if.ctl_dq_oe_n), .dev_dq_oe_n(i_drt_link_if.dev_dq_oe_n),
        .clash(i_drt_link_if.clash));
    initial
    begin
        forever #50 CLOCK = ~CLOCK;
    end
    // Stamps taken mid-cycle
    always @(negedge CLOCK)
    begin
        cyc++;
        case (i_drt_link_if.cmd)
            CMD_ACT:
            begin
                t_act0 = t_act;
                t_act = cyc;
            end
            CMD_RD: t_rd = cyc;
            CMD_WR: t_wr = cyc;
            CMD_PRE: t_pre = cyc;
            default: ;
        endcase
        if (RD_BUSY && dprev)
            t_beat = cyc;
        if (RD_BUSY)
            nb = dprev ? 1 : nb + 1;
        if (WR_BUSY && cprev)
            t_wf = cyc;
        dprev = !RD_BUSY;
        cprev = !WR_BUSY;
        if (i_drt_link_if.clash)
            seen_clash = 1;
    end
    task complete_run;
        if (errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task check(input string n, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", n, exp, got);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge CLOCK);
        PSEL <= 1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1;
        @(posedge CLOCK);
        for (i = 0; i < 20 && PREADY !== 1'b1; i++)
            @(posedge CLOCK);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 0;
        PENABLE <= 0;
        if (i == 20)
        begin
            errors++;
            complete_run;
        end
    endtask
    // Bounded polling; mask bit 1 waits for new read data to be set
    task wait_st(input logic [3:0] m);
        for (int i = 0; i < 300; i++)
        begin
            apb(0, REG_STATUS, '0);
            if ((rd[3:0] & m) === (m & 4'h2))
                return;
        end
        errors++;
        complete_run;
    endtask
    function automatic logic [31:0] cfg(logic [1:0] f, logic [4:0] al, logic w);
        return {14'h0000, w, 5'h09, al, 5'h0B, f};
    endfunction
    function automatic logic [31:0] req(drt_cmd_type op, logic [1:0] b, logic a12);
        return {23'h00_0000, a12, 2'h0, b, 1'h0, op};
    endfunction
    task send(input logic [7:0] a, input logic [31:0] d, input logic [3:0] m);
        apb(1, a, d);
        wait_st(m);
    endtask
    task t_regs;
        apb(0, REG_CFG, '0);
        check("cfg_reset", rd, CFG_RESET);
        apb(0, REG_WDATA, '0);
        check("wdata_reset", rd, WDATA_RESET);
        apb(0, 8'h20, '0);
        check("unmapped_err", er, 1);
        apb(1, REG_STATUS, 32'h0000_000F);
        check("ro_err", er, 1);
    endtask
    task t_burst(input logic [1:0] f, input logic a12, input int n, input logic [7:0] b);
        send(REG_CFG, cfg(f, 5'h00, 0), 4'hD);
        apb(1, REG_WDATA, {24'h00_0000, b});
        send(REG_REQ, req(CMD_WR, 2'h0, a12), 4'hD);
        send(REG_REQ, req(CMD_RD, 2'h0, a12), 4'hB);
        check("read_latency", t_beat - t_rd, 11);
        check("beats", nb, n);
        check("burst_long", BURST_LONG, n == 8);
        apb(0, REG_RDATA, '0);
        check("rdata", rd, {8'(b + n - 4), 8'(b + n - 3), 8'(b + n - 2), 8'(b + n - 1)});
    endtask
    task t_turn;
        send(REG_CFG, cfg(2'h0, 5'h00, 1), 4'hD);
        send(REG_REQ, req(CMD_RD, 2'h0, 1), 4'h1);
        send(REG_REQ, req(CMD_WR, 2'h0, 1), 4'hD);
        // Mode write waits for a quiet bus
        send(REG_CFG, cfg(2'h0, 5'h00, 0), 4'hD);
        check("rd_to_wr", t_wr - t_rd >= 11 + 8 + 1 - 10 + 2, 1);
        check("clash", seen_clash, 0);
        check("write_latency", t_wf - t_wr, 10);
    endtask
    task t_precharge;
        send(REG_CFG, cfg(2'h0, 5'h02, 0), 4'hD);
        send(REG_REQ, req(CMD_ACT, 2'h1, 1), 4'h1);
        send(REG_REQ, req(CMD_RD, 2'h1, 1), 4'h1);
        send(REG_REQ, req(CMD_PRE, 2'h1, 0), 4'h1);
        send(REG_REQ, req(CMD_ACT, 2'h1, 0), 4'hD);
        check("rd_to_pre", t_pre - t_rd >= 2 + 4, 1);
        check("act_to_pre", t_pre - t_act0 >= 28, 1);
        check("pre_to_act", t_act - t_pre >= 11 && t_act - t_act0 >= 39, 1);
        check("latency_al", t_beat - t_rd, 13);
    endtask
    initial
    begin
        repeat (3) @(posedge CLOCK);
        ARST_N <= 1;
        t_regs;
        t_burst(2'h0, 0, 8, 8'h10);
        t_burst(2'h1, 1, 8, 8'h20);
        t_burst(2'h1, 0, 4, 8'h30);
        t_burst(2'h2, 1, 4, 8'h40);
        t_burst(2'h3, 0, 8, 8'h50);
        t_turn;
        t_precharge;
        complete_run;
    end
endmodule
